//--- common/mdct_consts.vh
`ifndef MDCT_CONSTS_VH
`define MDCT_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MODE      12'h000
`define OFS_CTRL      12'h004
`define OFS_COUNT     12'h008
`define OFS_IRQ_FLAG  12'h00C
`define OFS_IRQ_MASK  12'h010
`define OFS_CLK_GATE  12'h014
`define OFS_IO_CTRL   12'h018
// ----------------------------------------
// field positions
// ----------------------------------------
`define SRC_HI        6
`define SRC_LO        4
`define MODE_HI       2
`define MODE_LO       0
`define EDGE_POL_BIT  3
`define START_BIT     0
`define STATUS_BIT    1
`define STOP_BIT      2
`define UNDF_BIT      5
`define EDGE_FLAG_BIT 4
`define IRQ_BIT       6
`define GATE_BIT      0
`define OUT_EN_BIT    2
`define INIT_LVL_BIT  0
// ----------------------------------------
// codes
// ----------------------------------------
`define SRC_FCLK      3'b000
`define SRC_DIV8      3'b001
`define SRC_DIV2      3'b011
`define SRC_LOW       3'b100
`define SRC_EVENT     3'b101
`define SRC_SUB       3'b110
`define MODE_TIMER    3'b000
`define MODE_PULSE    3'b001
`define MODE_EVENT    3'b010
`define MODE_WIDTH    3'b011
`define MODE_PERIOD   3'b100
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MODE      8'h00
`define RST_COUNT     16'hFFFF
`define RST_MASK      8'hFF
`define DIV8_LAST     3'd7
`endif

//--- hdl/multimode_down_counter_timer.v
// Notes on behaviour
// - mode bits 6:4 select count source
// - mode bits 2:0 select operating mode
// - underflow period is reload plus one counts
// - pulse mode decrements one per source tick
// - count at zero gives underflow and request
// - underflow toggles output pin, and io pin in pulse mode
// - output enable clear silences output pin only
// - output enable is io control bit 2
// - request flag is flag register bit 6
// - mask bit 6, one blocks servicing
// - start bit 0 starts and stops counting
// - clock gate zero holds reset, blocks writes except to flag, mask and gate
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mdct_consts.vh"
module multimode_down_counter_timer #(
	parameter CNT_W = 16
) (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        low_speed_clock,
	input  wire        sub_clock,
	input  wire        event_link_input,
	input  wire        irq_accept,
	input  wire        timer_io_pin_in,
	output reg         timer_io_pin_out,
	output wire        timer_io_pin_oe,
	output wire        timer_output_pin,
	output wire        timer_output_pin_oe,
	output wire        underflow_interrupt,
	output wire        irq
);
// ----------------------------------------
// synchronisers for pin and foreign clocks
// ----------------------------------------
localparam SYNC_LOW   = 0;
localparam SYNC_SUB   = 1;
localparam SYNC_EVENT = 2;
localparam SYNC_PIN   = 3;
reg  [3:0] sync1_q;
reg  [3:0] sync2_q;
reg  [3:0] prev_q;
always @(posedge clk_sys) begin
	if (sys_rst) begin
		sync1_q <= 4'h0;
		sync2_q <= 4'h0;
		prev_q  <= 4'h0;
	end else begin
		sync1_q <= {timer_io_pin_in, event_link_input, sub_clock, low_speed_clock};
		sync2_q <= sync1_q;
		prev_q  <= sync2_q;
	end
end
wire [3:0] rise = sync2_q & ~prev_q;
wire [3:0] fall = ~sync2_q & prev_q;
// ----------------------------------------
// registers
// ----------------------------------------
reg  [7:0]       mode_q;
reg              start_q;
reg              stop_req_q;
reg  [CNT_W-1:0] reload_q;
reg  [CNT_W-1:0] count_q;
reg              irq_flag_q;
reg              irq_mask_q;
reg              gate_q;
reg              out_en_q;
reg              init_lvl_q;
reg              undf_q;
reg              edgef_q;
reg  [2:0]       div_q;
reg              out_lvl_q;
wire wr = psel & penable & pwrite;
wire blk_rst = sys_rst | ~gate_q;
wire [2:0] src  = mode_q[`SRC_HI:`SRC_LO];
wire [2:0] mode = mode_q[`MODE_HI:`MODE_LO];
assign pready  = 1'b1;
assign pslverr = 1'b0;
// ----------------------------------------
// register write strobes
// ----------------------------------------
function reg_hit;
	input [11:0] a;
	input [11:0] o;
	begin
		reg_hit = (a == o);
	end
endfunction
wire wr_mode  = wr & reg_hit(paddr, `OFS_MODE);
wire wr_ctrl  = wr & reg_hit(paddr, `OFS_CTRL);
wire wr_count = wr & reg_hit(paddr, `OFS_COUNT);
wire wr_flag  = wr & reg_hit(paddr, `OFS_IRQ_FLAG);
wire wr_mask  = wr & reg_hit(paddr, `OFS_IRQ_MASK);
wire wr_gate  = wr & reg_hit(paddr, `OFS_CLK_GATE);
wire wr_io    = wr & reg_hit(paddr, `OFS_IO_CTRL);
// ----------------------------------------
// count source selection
// ----------------------------------------
function tick_sel;
	input [2:0] s;
	input [2:0] d;
	input [3:0] r;
	begin
		case (s)
			`SRC_FCLK:  tick_sel = 1'b1;
			`SRC_DIV8:  tick_sel = (d == `DIV8_LAST);
			`SRC_DIV2:  tick_sel = d[0];
			`SRC_LOW:   tick_sel = r[0];
			`SRC_EVENT: tick_sel = r[2];
			`SRC_SUB:   tick_sel = r[1];
			default:    tick_sel = 1'b0;
		endcase
	end
endfunction
function edge_sel;
	input pol;
	input r;
	input f;
	begin
		edge_sel = pol ? f : r;
	end
endfunction
wire src_tick = tick_sel(src, div_q, rise);
wire pin_edge = edge_sel(mode_q[`EDGE_POL_BIT], rise[SYNC_PIN], fall[SYNC_PIN]);
wire pin_lvl  = mode_q[`EDGE_POL_BIT] ? ~sync2_q[SYNC_PIN] : sync2_q[SYNC_PIN];
reg  tick;
reg  measure;
always @* begin
	tick    = 1'b0;
	measure = 1'b0;
	case (mode)
		`MODE_TIMER:  tick = src_tick;
		`MODE_PULSE:  tick = src_tick;
		`MODE_EVENT:  tick = pin_edge;
		`MODE_WIDTH: begin
			tick    = src_tick & pin_lvl;
			measure = 1'b1;
		end
		`MODE_PERIOD: begin
			tick    = src_tick;
			measure = 1'b1;
		end
		default:      tick = 1'b0;
	endcase
end
wire running = start_q & ~stop_req_q;
wire counting = running & tick;
wire underflow = counting & (count_q == {CNT_W{1'b0}});
wire width_end = edge_sel(mode_q[`EDGE_POL_BIT], fall[SYNC_PIN], rise[SYNC_PIN]);
wire meas_end = running & measure & ((mode == `MODE_WIDTH) ? width_end : pin_edge);
wire irq_event = underflow | meas_end;
assign underflow_interrupt = irq_event;
assign irq = irq_flag_q & ~irq_mask_q;
// ----------------------------------------
// count source divider
// ----------------------------------------
always @(posedge clk_sys) begin
	if (blk_rst)
		div_q <= 3'd0;
	else
		div_q <= div_q + 3'd1;
end
// ----------------------------------------
// configuration registers
// ----------------------------------------
always @(posedge clk_sys) begin
	if (blk_rst) begin
		mode_q     <= `RST_MODE;
		out_en_q   <= 1'b0;
		init_lvl_q <= 1'b0;
	end else begin
		if (wr_mode)
			mode_q <= {1'b0, pwdata[6:0]};
		if (wr_io) begin
			out_en_q   <= pwdata[`OUT_EN_BIT];
			init_lvl_q <= pwdata[`INIT_LVL_BIT];
		end
	end
end
// ----------------------------------------
// start, stop and counter
// ----------------------------------------
always @(posedge clk_sys) begin
	if (blk_rst) begin
		start_q    <= 1'b0;
		stop_req_q <= 1'b0;
		reload_q   <= `RST_COUNT;
		count_q    <= `RST_COUNT;
	end else begin
		stop_req_q <= 1'b0;
		if (underflow)
			count_q <= reload_q;
		else if (meas_end)
			count_q <= reload_q;
		else if (counting)
			count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
		if (wr_ctrl) begin
			start_q    <= pwdata[`START_BIT] & ~pwdata[`STOP_BIT];
			stop_req_q <= pwdata[`STOP_BIT];
		end
		if (wr_count) begin
			reload_q <= pwdata[CNT_W-1:0];
			count_q  <= pwdata[CNT_W-1:0];
		end
	end
end
// ----------------------------------------
// status flags and output level
// ----------------------------------------
always @(posedge clk_sys) begin
	if (blk_rst) begin
		undf_q    <= 1'b0;
		edgef_q   <= 1'b0;
		out_lvl_q <= 1'b1;
	end else begin
		if (underflow)
			undf_q <= 1'b1;
		else if (wr_ctrl && !pwdata[`UNDF_BIT])
			undf_q <= 1'b0;
		if (running & pin_edge)
			edgef_q <= 1'b1;
		else if (wr_ctrl && !pwdata[`EDGE_FLAG_BIT])
			edgef_q <= 1'b0;
		if (underflow)
			out_lvl_q <= ~out_lvl_q;
		else if (wr_ctrl && pwdata[`START_BIT] && !start_q)
			out_lvl_q <= ~init_lvl_q;
	end
end
// ----------------------------------------
// interrupt flag, mask and clock gate
// ----------------------------------------
always @(posedge clk_sys) begin
	if (sys_rst)
		irq_flag_q <= 1'b0;
	else if (irq_event)
		irq_flag_q <= 1'b1;
	else if (irq_accept || (wr_flag && !pwdata[`IRQ_BIT]))
		irq_flag_q <= 1'b0;
	else if (wr_flag)
		irq_flag_q <= 1'b1;
end
always @(posedge clk_sys) begin
	if (sys_rst)
		irq_mask_q <= 1'b1;
	else if (wr_mask)
		irq_mask_q <= pwdata[`IRQ_BIT];
end
always @(posedge clk_sys) begin
	if (sys_rst)
		gate_q <= 1'b0;
	else if (wr_gate)
		gate_q <= pwdata[`GATE_BIT];
end
// ----------------------------------------
// pins
// ----------------------------------------
wire pulse_mode = (mode == `MODE_PULSE);
always @(posedge clk_sys) begin
	if (blk_rst)
		timer_io_pin_out <= 1'b0;
	else
		timer_io_pin_out <= out_lvl_q;
end
assign timer_io_pin_oe     = pulse_mode & ~blk_rst;
assign timer_output_pin    = timer_io_pin_out & out_en_q;
assign timer_output_pin_oe = out_en_q;
// ----------------------------------------
// read data
// ----------------------------------------
reg  [31:0] prdata_d;
always @* begin
	case (paddr)
		`OFS_MODE:     prdata_d = {{24{1'b0}}, mode_q};
		`OFS_CTRL:     prdata_d = {{26{1'b0}}, undf_q, edgef_q, 2'b00, running, start_q};
		`OFS_COUNT:    prdata_d = {{(32-CNT_W){1'b0}}, count_q};
		`OFS_IRQ_FLAG: prdata_d = {{25{1'b0}}, irq_flag_q, 6'h00};
		`OFS_IRQ_MASK: prdata_d = {{25{1'b0}}, irq_mask_q, 6'h00};
		`OFS_CLK_GATE: prdata_d = {{31{1'b0}}, gate_q};
		`OFS_IO_CTRL:  prdata_d = {{29{1'b0}}, out_en_q, 1'b0, init_lvl_q};
		default:       prdata_d = 32'h0000_0000;
	endcase
end
always @(posedge clk_sys) begin
	if (sys_rst)
		prdata <= 32'h0000_0000;
	else if (psel && !penable && !pwrite)
		prdata <= prdata_d;
end
endmodule
`default_nettype wire

//--- verification/mdct_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mdct_sva (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_accept,
	input wire logic timer_io_pin_out,
	input wire logic timer_io_pin_oe,
	input wire logic timer_output_pin,
	input wire logic timer_output_pin_oe,
	input wire logic underflow_interrupt,
	input wire logic irq
);
	wire logic apb_wr = psel && penable && pwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_no_err: assert property (!pslverr)
		else $error("pslverr raised");
	chk_out_gated: assert property (!timer_output_pin_oe |-> !timer_output_pin)
		else $error("output pin driven while disabled");
	chk_out_follow: assert property (timer_output_pin_oe |-> timer_output_pin == timer_io_pin_out)
		else $error("output pin differs from io pin");
	chk_io_toggle: assert property (underflow_interrupt && timer_io_pin_oe
		|=> ##1 timer_io_pin_out != $past(timer_io_pin_out))
		else $error("io pin not inverted at underflow");
	chk_irq_hold: assert property (irq && !apb_wr && !irq_accept |=> irq)
		else $error("request dropped by itself");
	chk_accept_clr: assert property (irq_accept && !underflow_interrupt && !apb_wr |=> !irq)
		else $error("accept did not clear request");
	chk_irq_rise: assert property ($rose(irq) |-> $past(underflow_interrupt) || $past(apb_wr))
		else $error("request without cause");
	chk_irq_fall: assert property ($fell(irq) |-> $past(irq_accept) || $past(apb_wr)
		|| $past(sys_rst))
		else $error("request fell without cause");
endmodule
bind multimode_down_counter_timer mdct_sva mdct_sva_inst (.*);
`default_nettype wire

//--- verification/multimode_down_counter_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "mdct_consts.vh"
module multimode_down_counter_timer_test;
	logic        clk_sys, sys_rst, psel, penable, pwrite, ev, ack, lv;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire logic   pready, pslverr, io_o, io_oe, op, op_oe, uf, irq;
	wire logic [31:0] prdata;
	int          failures, n_tests, p, n;
	integer      seed = 32'h63f2_5d9d;
	int          dv[3] = '{1, 8, 2};
	logic [2:0]  sc[3] = '{`SRC_FCLK, `SRC_DIV8, `SRC_DIV2};
	logic [6:0]  ec[4] = '{{`SRC_EVENT, 4'h0}, {`SRC_LOW, 4'h0}, {`SRC_SUB, 4'h0},
		{4'h0, `MODE_EVENT}};
	function int exp_period(input int r, input int d);
		return (r + 1) * d;
	endfunction
	multimode_down_counter_timer multimode_down_counter_timer_inst (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.low_speed_clock(ev), .sub_clock(ev), .event_link_input(ev), .irq_accept(ack),
		.timer_io_pin_in(ev), .timer_io_pin_out(io_o), .timer_io_pin_oe(io_oe),
		.timer_output_pin(op), .timer_output_pin_oe(op_oe), .underflow_interrupt(uf), .irq(irq));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task per(output int q);
		int k;
		k = 0;
		q = 0;
		while (uf !== 1'b1 && k < 3000) begin
			@(negedge clk_sys);
			k++;
		end
		do begin
			@(negedge clk_sys);
			q++;
		end while (uf !== 1'b1 && q < 3000);
	endtask
	// ----------------------------------------
	// clock, watchdog, stimulus
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		failures++;
		end_of_test;
	end
	initial begin
		{psel, penable, pwrite, ev, ack} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		apb(0, `OFS_MODE, 0);
		chk("mode reset", rd, 0);
		apb(0, `OFS_IRQ_MASK, 0);
		chk("mask reset", rd, 32'h0000_0040);
		apb(0, 12'h020, 0);
		chk("unmapped", rd, 0);
		apb(1, `OFS_MODE, 1);
		apb(0, `OFS_MODE, 0);
		chk("gated write", rd, 0);
		apb(1, `OFS_CLK_GATE, 1);
		for (int i = 0; i < 3; i++) begin
			n = 1 + ($random(seed) & 7);
			apb(1, `OFS_COUNT, n);
			apb(1, `OFS_MODE, {sc[i], 4'h0});
			apb(1, `OFS_CTRL, 1);
			per(p);
			chk("period", p, exp_period(n, dv[i]));
			apb(1, `OFS_CTRL, 0);
		end
		for (int m = 0; m < 5; m++) begin
			apb(1, `OFS_MODE, m);
			apb(0, `OFS_MODE, 0);
			chk("mode code", rd, m);
		end
		for (int e = 0; e < 4; e++) begin
			apb(1, `OFS_COUNT, 1);
			apb(1, `OFS_MODE, ec[e]);
			apb(1, `OFS_CTRL, 1);
			p = 0;
			for (int k = 0; k < 24; k++) begin
				@(posedge clk_sys);
				ev <= k[2];
				@(negedge clk_sys);
				p += uf;
			end
			chk("event underflows", p, 1);
			apb(1, `OFS_CTRL, 0);
		end
		apb(1, `OFS_IRQ_FLAG, 0);
		apb(1, `OFS_IRQ_MASK, 0);
		apb(1, `OFS_COUNT, 3);
		apb(1, `OFS_MODE, 0);
		apb(1, `OFS_CTRL, 1);
		per(p);
		chk("timer period", p, exp_period(3, 1));
		apb(1, `OFS_CTRL, 0);
		@(negedge clk_sys);
		chk("irq set", irq, 1);
		apb(0, `OFS_IRQ_FLAG, 0);
		chk("flag bit", rd[6], 1);
		apb(1, `OFS_IRQ_MASK, 32'h0000_0040);
		@(negedge clk_sys);
		chk("irq masked", irq, 0);
		apb(1, `OFS_IRQ_MASK, 0);
		@(posedge clk_sys);
		ack <= 1'b1;
		@(posedge clk_sys);
		ack <= 1'b0;
		@(negedge clk_sys);
		chk("irq accepted", irq, 0);
		apb(1, `OFS_IRQ_FLAG, 32'h0000_0040);
		@(negedge clk_sys);
		chk("flag write one", irq, 1);
		apb(1, `OFS_IRQ_FLAG, 0);
		@(negedge clk_sys);
		chk("flag write zero", irq, 0);
		apb(1, `OFS_IO_CTRL, 32'h0000_0004);
		apb(0, `OFS_IO_CTRL, 0);
		chk("out enable bit", rd[2], 1);
		apb(1, `OFS_COUNT, 2);
		apb(1, `OFS_MODE, `MODE_PULSE);
		apb(1, `OFS_CTRL, 1);
		per(p);
		chk("pulse period", p, exp_period(2, 1));
		lv = io_o;
		repeat (2) @(negedge clk_sys);
		chk("io toggle", io_o, !lv);
		chk("out pin", {io_oe, op}, {1'b1, io_o});
		apb(1, `OFS_IO_CTRL, 0);
		per(p);
		chk("out pin off", {op_oe, op}, 0);
		chk("count kept", p, exp_period(2, 1));
		end_of_test;
	end
endmodule
`default_nettype wire
